// ### pds_pkg.sv
/*
  Constants, timing figures and state encoding of the pulse dial sequencer.
  Assumes a 20 MHz system clock; all tick figures count internal ticks.
*/
package pds_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned T_ON_MS = 4;
  localparam int unsigned T_ON_CYC = (T_ON_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Dialling pulse period, normal and test rate, in microseconds
  localparam int unsigned TDP_NORMAL_US = 98700;
  localparam int unsigned TDP_TEST_US = 1073;
  // Prepulse of ten ticks is a third of the pulse period
  localparam int unsigned TICKS_PER_TDP = 30;
  localparam int unsigned TICK_NORMAL_CYC = (TDP_NORMAL_US * 1000) / (TICKS_PER_TDP * CLK_PERIOD_NS);
  localparam int unsigned TICK_TEST_CYC = (TDP_TEST_US * 1000) / (TICKS_PER_TDP * CLK_PERIOD_NS);

  // ==========================================================
  // Phase lengths in ticks
  localparam int unsigned PHASE_W = 8;
  localparam int unsigned GAP_TDP = 8;
  localparam int unsigned RD_TDP_X10 = 16;
  localparam logic [PHASE_W-1:0] PREWAIT_TICKS = 8'h0a;
  localparam logic [PHASE_W-1:0] PREPULSE_TICKS = 8'h0a;
  localparam logic [PHASE_W-1:0] BREAK_TICKS = PHASE_W'((3 * TICKS_PER_TDP) / 5);
  localparam logic [PHASE_W-1:0] MAKE_TICKS = PHASE_W'((2 * TICKS_PER_TDP) / 5);
  localparam logic [PHASE_W-1:0] GAP_TICKS = PHASE_W'(GAP_TDP * TICKS_PER_TDP);
  localparam logic [PHASE_W-1:0] RD_TICKS = PHASE_W'((RD_TDP_X10 * TICKS_PER_TDP) / 10);

  // ==========================================================
  // Keycodes and store
  localparam int unsigned KEY_W = 4;
  localparam int unsigned RAM_DEPTH = 23;
  localparam logic [KEY_W-1:0] KEY_REDIAL = 4'hb;
  localparam logic [KEY_W-1:0] KEY_ZERO = 4'h0;
  localparam logic [KEY_W-1:0] ZERO_PULSES = 4'ha;

  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_STANDBY  = 4'h0,
    ST_START    = 4'h1,
    ST_PREWAIT  = 4'h2,
    ST_PREPULSE = 4'h3,
    ST_IDLE     = 4'h4,
    ST_GAP      = 4'h5,
    ST_FETCH    = 4'h6,
    ST_LOAD     = 4'h7,
    ST_BREAK    = 4'h8,
    ST_MAKE     = 4'h9
  } pds_state_t;

endpackage

// ### pds_keyram.sv
/*
  Keycode store of the pulse dial sequencer: one write port, one read port
  with registered read data. Contents are not reset and survive standby.
*/
`timescale 1ns/1ps
module pds_keyram #(
  parameter int unsigned DEPTH = 23,
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 4
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // Read port
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### pds_sequencer.sv
/*
  Pulse dial sequencer: start-up, mute prepulse, keycode storage and
  replay as timed line pulses, hold and long-enable-low standby.
  Assumes debounced keycodes arrive as one-cycle strobes and all inputs
  are synchronous to sys_clk.
*/
// Notes on behaviour
// RQ1 - Tick generator starts 4 ms after enable
// RQ2 - Ten ticks later, ten-tick prepulse on mute
// RQ3 - Common-contact start: mute high after entry
// RQ4 - Stored key raises mute, then inter-digit gap
// RQ5 - After gap: strobe, read key, pulse count
// RQ6 - Digit end: strobe low, read pointer advances
// RQ7 - All digits sent: mute low, conversation
// RQ8 - Enable low 1,6 periods returns standby
// RQ9 - Hold stops train when strobe falls
// RQ10 - Keys still stored while hold is high
// RQ11 - Resume only after hold low plus gap
// RQ12 - Over 23 keys wraps, blocks redial
// RQ13 - First-key redial replays, ignores new keys
// RQ14 - Standby clears all except store, write pointer, overflow flag
// RQ15 - Inter-digit gap lasts eight pulse periods
// RQ16 - Digit n gives n pulses, zero gives ten, 3/5 break
// RQ17 - Strobe high over train, low in gap
`timescale 1ns/1ps
module pds_sequencer
  import pds_pkg::*;
#(
  parameter int unsigned T_ON_CYCLES = pds_pkg::T_ON_CYC,
  parameter int unsigned TICK_NORMAL_CYCLES = pds_pkg::TICK_NORMAL_CYC,
  parameter int unsigned TICK_TEST_CYCLES = pds_pkg::TICK_TEST_CYC,
  parameter int unsigned DEPTH = pds_pkg::RAM_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control inputs
  input wire logic enable_in,
  input wire logic rate_select_in,
  input wire logic hold_in,
  // Debounced keyboard entry
  input wire logic key_valid_in,
  input wire logic [pds_pkg::KEY_W-1:0] key_code_in,
  // Line side outputs
  output logic mute_out,
  output logic digit_strobe_out,
  output logic line_pulse_out
);
  import pds_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned TW = $clog2(T_ON_CYCLES + 1);
  localparam int unsigned DW = $clog2(TICK_NORMAL_CYCLES + 1);

  // ==========================================================
  // Pointer wrap
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    logic [AW-1:0] r;
    r = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    return r;
  endfunction

  pds_state_t state_q, state_d;
  logic [TW-1:0] start_cnt_q;
  logic [DW-1:0] tick_div_q;
  logic internal_tick_q;
  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] low_cnt_q;
  logic [KEY_W-1:0] pulses_q;
  logic [AW-1:0] read_pointer_q, write_pointer_q;
  logic overflow_q, first_q, replay_q;
  logic [KEY_W-1:0] ram_q;

  // ==========================================================
  // Decoding
  wire running = (state_q != ST_STANDBY) && (state_q != ST_START);
  wire standby = (state_q == ST_STANDBY);
  wire [DW-1:0] tick_lim = rate_select_in ? DW'(TICK_TEST_CYCLES - 1) : DW'(TICK_NORMAL_CYCLES - 1);
  wire tick_end = running && (tick_div_q >= tick_lim);
  wire start_done = (start_cnt_q == TW'(T_ON_CYCLES - 1));
  wire [PHASE_W-1:0] phase_lim = (state_q == ST_PREWAIT) ? PREWAIT_TICKS :
                                 (state_q == ST_PREPULSE) ? PREPULSE_TICKS :
                                 (state_q == ST_GAP) ? GAP_TICKS :
                                 (state_q == ST_BREAK) ? BREAK_TICKS : MAKE_TICKS;
  wire phase_done = internal_tick_q && (phase_q == phase_lim - PHASE_W'(1));
  // RQ8 - reset pulse detect
  wire reset_pulse = running && !enable_in && internal_tick_q && (low_cnt_q == RD_TICKS - PHASE_W'(1));
  // Digits of an earlier call stay for redial and must not pend
  wire pending = !first_q && (read_pointer_q != write_pointer_q);
  wire last_digit = (ptr_inc(read_pointer_q) == write_pointer_q);
  wire digit_end = (state_q == ST_MAKE) && phase_done && (pulses_q == KEY_W'(1));
  // RQ10 - keys taken in hold too
  wire key_take = running && key_valid_in && !replay_q;
  wire key_is_redial = (key_code_in == KEY_REDIAL);
  // RQ12 - redial blocked after overflow
  wire key_first_redial = key_take && first_q && key_is_redial && !overflow_q;
  wire key_store = key_take && !key_is_redial;
  wire [AW-1:0] wr_addr = first_q ? '0 : write_pointer_q;
  wire replay_done = (state_q == ST_IDLE) && !pending;
  // RQ9 - hold clears gap count
  wire phase_clr = (state_d != state_q) || ((state_q == ST_GAP) && hold_in);
  wire [KEY_W-1:0] load_pulses = (ram_q == KEY_ZERO) ? ZERO_PULSES : ram_q;
  // RQ4 - mute follows next state
  wire mute_d = (state_d == ST_PREPULSE) || (state_d == ST_GAP) || (state_d == ST_FETCH) ||
                (state_d == ST_LOAD) || (state_d == ST_BREAK) || (state_d == ST_MAKE);
  // RQ17 - strobe over whole train
  wire strobe_d = (state_d == ST_FETCH) || (state_d == ST_LOAD) || (state_d == ST_BREAK) ||
                  (state_d == ST_MAKE);
  wire pulse_d = (state_d == ST_BREAK);

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_STANDBY: begin
        if (enable_in) state_d = ST_START;
      end
      // RQ1 - start-up delay
      ST_START: begin
        if (!enable_in) state_d = ST_STANDBY;
        else if (start_done) state_d = ST_PREWAIT;
      end
      // RQ3 - early key mutes at once
      ST_PREWAIT: begin
        if (pending) state_d = ST_GAP;
        else if (phase_done) state_d = ST_PREPULSE;
      end
      // RQ2 - prepulse then conversation
      ST_PREPULSE: begin
        if (phase_done) state_d = pending ? ST_GAP : ST_IDLE;
      end
      ST_IDLE: begin
        if (pending) state_d = ST_GAP;
      end
      // RQ11 - gap restarts while held
      ST_GAP: begin
        if (phase_done && !hold_in) state_d = ST_FETCH;
      end
      ST_FETCH: state_d = ST_LOAD;
      ST_LOAD: state_d = ST_BREAK;
      // RQ16 - break then make
      ST_BREAK: begin
        if (phase_done) state_d = ST_MAKE;
      end
      // RQ7 - last digit back to conversation
      ST_MAKE: begin
        if (digit_end) state_d = last_digit ? ST_IDLE : ST_GAP;
        else if (phase_done) state_d = ST_BREAK;
      end
      default: state_d = ST_STANDBY;
    endcase
    if (reset_pulse) state_d = ST_STANDBY;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= ST_STANDBY;
      mute_out <= 1'b0;
      digit_strobe_out <= 1'b0;
      line_pulse_out <= 1'b0;
    end else begin
      state_q <= state_d;
      mute_out <= mute_d;
      digit_strobe_out <= strobe_d;
      line_pulse_out <= pulse_d;
    end
  end

  // ==========================================================
  // Start-up, tick divider and enable-low watch
  // Divider is idle in standby, standing in for the stopped oscillator
  always_ff @(posedge sys_clk) begin
    if (sys_rst || state_q != ST_START) start_cnt_q <= '0;
    else start_cnt_q <= start_cnt_q + TW'(1);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running || tick_end) tick_div_q <= '0;
    else tick_div_q <= tick_div_q + DW'(1);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) internal_tick_q <= 1'b0;
    else internal_tick_q <= tick_end;
  end

  // Short enable drops while running clear the count and do nothing else
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !running || enable_in) low_cnt_q <= '0;
    else if (internal_tick_q) low_cnt_q <= low_cnt_q + PHASE_W'(1);
  end

  // RQ15 - phase timing in ticks
  always_ff @(posedge sys_clk) begin
    if (sys_rst || phase_clr) phase_q <= '0;
    else if (internal_tick_q) phase_q <= phase_q + PHASE_W'(1);
  end

  // RQ5 - pulse count from keycode
  always_ff @(posedge sys_clk) begin
    if (sys_rst || standby) pulses_q <= '0;
    else if (state_q == ST_LOAD) pulses_q <= load_pulses;
    else if (state_q == ST_MAKE && phase_done) pulses_q <= pulses_q - KEY_W'(1);
  end

  // ==========================================================
  // Pointers and entry flags
  // RQ14 - write pointer survives standby
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      write_pointer_q <= '0;
      overflow_q <= 1'b0;
    end else if (key_store) begin
      write_pointer_q <= ptr_inc(wr_addr);
      // RQ12 - wrap onto lowest location
      overflow_q <= !first_q && (write_pointer_q == '0) ? 1'b1 : (first_q ? 1'b0 : overflow_q);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || standby) begin
      read_pointer_q <= '0;
      first_q <= 1'b1;
      replay_q <= 1'b0;
    end else begin
      // RQ13 - redial first replays store
      if (key_first_redial) begin
        read_pointer_q <= '0;
        replay_q <= 1'b1;
      end else if (key_store && first_q) begin
        read_pointer_q <= '0;
      end else if (digit_end) begin
        // RQ6 - advance after each digit
        read_pointer_q <= ptr_inc(read_pointer_q);
      end
      if (key_first_redial || key_store) first_q <= 1'b0;
      if (replay_done && !key_first_redial) replay_q <= 1'b0;
    end
  end

  pds_keyram #(
    .DEPTH(DEPTH),
    .AW(AW),
    .DW(KEY_W)
  ) u_keyram (
    .sys_clk(sys_clk),
    .wr_en(key_store),
    .wr_addr(wr_addr),
    .wr_data(key_code_in),
    .rd_en(state_q == ST_FETCH),
    .rd_addr(read_pointer_q),
    .rd_data(ram_q)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence seq_digit_open;
    state_q == ST_FETCH ##1 state_q == ST_LOAD ##1 (state_q == ST_BREAK && line_pulse_out);
  endsequence

  AST_START_DELAY: assert property ( // RQ1
    $rose(state_q == ST_PREWAIT) |-> $past(state_q) == ST_START && $past(start_cnt_q) == TW'(T_ON_CYCLES - 1)
  ) else $error("tick start not after start-up delay");
  AST_PREPULSE: assert property ( // RQ2
    $rose(state_q == ST_PREPULSE) |-> mute_out && $past(phase_q) == PREWAIT_TICKS - PHASE_W'(1)
  ) else $error("prepulse timing wrong");
  AST_GAP_MUTE: assert property ( // RQ4
    state_q == ST_GAP |-> mute_out && !digit_strobe_out && !line_pulse_out
  ) else $error("gap without mute or with strobe");
  AST_DIGIT_OPEN: assert property ( // RQ5
    disable iff (sys_rst || !enable_in) $rose(state_q == ST_FETCH) |-> digit_strobe_out and seq_digit_open
  ) else $error("digit start sequence wrong");
  AST_READ_ADVANCE: assert property ( // RQ6
    $fell(digit_strobe_out) && state_q != ST_STANDBY |-> read_pointer_q == ptr_inc($past(read_pointer_q))
  ) else $error("read pointer not advanced at digit end");
  AST_CONV_MUTE: assert property ( // RQ7
    state_q == ST_IDLE |-> !mute_out && !digit_strobe_out
  ) else $error("conversation with mute high");
  AST_RESET_STANDBY: assert property ( // RQ8
    reset_pulse |=> state_q == ST_STANDBY && !mute_out && !line_pulse_out ##1 read_pointer_q == '0
  ) else $error("long enable low did not reach standby");
  AST_HOLD_GAP: assert property ( // RQ11
    state_q == ST_GAP && hold_in && !reset_pulse |=> state_q == ST_GAP && phase_q == '0
  ) else $error("gap ran on under hold");
  AST_HOLD_STORE: assert property ( // RQ10
    key_store && hold_in |=> write_pointer_q == ptr_inc($past(wr_addr))
  ) else $error("key lost during hold");
  AST_REDIAL_BLOCK: assert property ( // RQ12
    running && key_valid_in && first_q && key_is_redial && overflow_q |=> !replay_q
  ) else $error("redial allowed after overflow");
  AST_REDIAL_KEEP: assert property ( // RQ13
    key_first_redial |=> $stable(write_pointer_q) && replay_q
  ) else $error("redial disturbed write pointer");
  AST_GAP_LEN: assert property ( // RQ15
    $rose(state_q == ST_FETCH) |-> $past(phase_q) == GAP_TICKS - PHASE_W'(1) && !$past(hold_in)
  ) else $error("inter-digit gap length wrong");
  AST_BREAK_LEN: assert property ( // RQ16
    $fell(line_pulse_out) && state_q == ST_MAKE |-> $past(phase_q) == BREAK_TICKS - PHASE_W'(1)
  ) else $error("break length wrong");
  AST_PULSE_STROBE: assert property ( // RQ17
    line_pulse_out |-> digit_strobe_out
  ) else $error("line pulse outside strobe");

endmodule

// ### pds_line_model.sv
/*
  Line side model of the pulse dial sequencer: counts line breaks per digit,
  measures break, make and gap lengths and drives the hold input.
  Assumes all sequencer outputs are registered on the rising sys_clk edge.
*/
`timescale 1ns/1ps
module pds_line_model (
  // Clock
  input wire logic sys_clk,
  // Hold request from the bench
  input wire logic hold_cmd,
  output logic hold_in,
  // Sequencer line outputs
  input wire logic mute_out,
  input wire logic digit_strobe_out,
  input wire logic line_pulse_out
);
  // ==========================================================
  // Observed figures
  int digits[$];
  int pulses = 0;
  int brk = 0;
  int mk = 0;
  int gap = 0;
  int gap_run = 0;
  int stray = 0;
  int run = 0;
  logic pulse_q = 1'b0;
  logic strobe_q = 1'b0;

  // ==========================================================
  // Exchange side hold
  // hold raised and dropped here
  always @(negedge sys_clk) hold_in <= hold_cmd;

  // ==========================================================
  // Line watching
  always @(posedge sys_clk) begin
    pulse_q <= line_pulse_out;
    strobe_q <= digit_strobe_out;
    // Run holds the length of the level just ended
    run <= (line_pulse_out !== pulse_q) ? 1 : run + 1;
    if (line_pulse_out === 1'b1 && pulse_q === 1'b0) begin
      pulses <= pulses + 1;
      mk <= run;
      if (digit_strobe_out !== 1'b1) stray <= stray + 1;
    end
    if (line_pulse_out === 1'b0 && pulse_q === 1'b1) brk <= run;
    gap_run <= (digit_strobe_out === 1'b1) ? 0 : gap_run + int'(mute_out === 1'b1);
    if (digit_strobe_out === 1'b1 && strobe_q === 1'b0) gap <= gap_run;
    if (digit_strobe_out === 1'b0 && strobe_q === 1'b1) begin
      digits.push_back(pulses);
      pulses <= 0;
    end
  end
endmodule

// ### tb_top.sv
/*
  Self-checking bench of the pulse dial sequencer with shortened timing.
  Assumes pds_pkg, pds_sequencer and pds_line_model are compiled first.
*/
`timescale 1ns/1ps
module tb_top;
  import pds_pkg::*;
  // ==========================================================
  // Set-up
  localparam int TON = 20;
  localparam int TK = 4;
  localparam int GAP = 240 * TK;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic enable_in = 1'b0;
  logic rate_select_in = 1'b1;
  logic hold_cmd = 1'b0;
  logic hold_in;
  logic key_valid_in = 1'b0;
  logic [KEY_W-1:0] key_code_in = 4'h0;
  logic mute_out;
  logic digit_strobe_out;
  logic line_pulse_out;
  int n_errors = 0;
  int compares = 0;
  int n;

  always #25 sys_clk = ~sys_clk;

  pds_sequencer #(.T_ON_CYCLES(TON), .TICK_NORMAL_CYCLES(8), .TICK_TEST_CYCLES(TK)) dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .enable_in(enable_in), .rate_select_in(rate_select_in),
    .hold_in(hold_in), .key_valid_in(key_valid_in), .key_code_in(key_code_in), .mute_out(mute_out),
    .digit_strobe_out(digit_strobe_out), .line_pulse_out(line_pulse_out));

  pds_line_model line (.sys_clk(sys_clk), .hold_cmd(hold_cmd), .hold_in(hold_in), .mute_out(mute_out),
    .digit_strobe_out(digit_strobe_out), .line_pulse_out(line_pulse_out));

  // ==========================================================
  // Helpers
  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    compares++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic check_digits(input int exp[$]);
    // Model logs the last digit one edge after the strobe falls
    @(posedge sys_clk);
    #1;
    check_eq(line.digits.size(), exp.size());
    foreach (exp[i]) check_eq(line.digits[i], exp[i]);
    line.digits.delete();
  endtask

  // Bounded wait; a timeout returns lim so the caller's range check fails
  task automatic wait_out(input int sel, input logic val, input int lim, output int cyc);
    cyc = 0;
    while (cyc < lim && (sel == 0 ? mute_out : digit_strobe_out) !== val) begin
      @(posedge sys_clk);
      #1;
      cyc++;
    end
  endtask

  task automatic press(input logic [3:0] c);
    @(negedge sys_clk);
    key_valid_in = 1'b1;
    key_code_in = c;
    @(negedge sys_clk);
    key_valid_in = 1'b0;
  endtask

  // Long enable low forces standby, then a fresh start-up is measured
  task automatic boot(input logic r);
    int tk;
    tk = r ? TK : 8;
    @(negedge sys_clk);
    enable_in = 1'b0;
    rate_select_in = r;
    repeat (450) @(negedge sys_clk);
    enable_in = 1'b1;
    wait_out(0, 1'b1, 2000, n);
    check_in(n, TON + 9 * tk, TON + 11 * tk + 3);
    wait_out(0, 1'b0, 200, n);
    check_eq(n, 10 * tk);
    line.digits.delete();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_dial();
    press(4'h3);
    wait_out(0, 1'b1, 10, n);
    check_eq(n, 1);
    press(KEY_ZERO);
    wait_out(0, 1'b0, 6000, n);
    check_in(n, GAP, 5999);
    check_digits('{3, 10});
    check_in(line.gap, GAP - 4, GAP + 4);
    check_eq(line.brk, 18 * TK);
    check_eq(line.mk, 12 * TK);
    check_eq(line.stray, 0);
    check_eq({digit_strobe_out, line_pulse_out}, 2'b00);
  endtask

  task automatic t_hold();
    boot(1'b1);
    press(4'h2);
    press(4'h1);
    wait_out(1, 1'b1, GAP + 20, n);
    @(negedge sys_clk);
    hold_cmd <= 1'b1;
    wait_out(1, 1'b0, 400, n);
    check_in(n, 220, 260);
    press(4'h5);
    wait_out(1, 1'b1, 1500, n);
    check_eq(n, 1500);
    @(negedge sys_clk);
    hold_cmd <= 1'b0;
    wait_out(1, 1'b1, GAP + 20, n);
    check_in(n, GAP - 4, GAP + 8);
    wait_out(0, 1'b0, 4000, n);
    check_digits('{2, 1, 5});
  endtask

  task automatic t_redial();
    boot(1'b0);
    press(KEY_REDIAL);
    press(4'h7);
    wait_out(1, 1'b1, 2100, n);
    // Short enable drop of 25 ticks must not disturb the replay
    @(negedge sys_clk);
    enable_in = 1'b0;
    repeat (200) @(negedge sys_clk);
    enable_in = 1'b1;
    wait_out(0, 1'b0, 12000, n);
    check_digits('{2, 1, 5});
    check_eq(mute_out, 1'b0);
  endtask

  task automatic t_cut();
    boot(1'b1);
    press(4'h9);
    wait_out(1, 1'b1, GAP + 20, n);
    @(negedge sys_clk);
    enable_in = 1'b0;
    wait_out(0, 1'b0, 300, n);
    check_in(n, 47 * TK, 48 * TK + 3);
    check_eq({digit_strobe_out, line_pulse_out}, 2'b00);
    @(negedge sys_clk);
    enable_in = 1'b1;
    wait_out(0, 1'b1, 2000, n);
    check_in(n, TON + 9 * TK, TON + 11 * TK + 3);
    wait_out(0, 1'b0, 200, n);
    line.digits.delete();
  endtask

  task automatic t_ovf();
    boot(1'b1);
    repeat (24) press(4'h1);
    wait_out(0, 1'b0, 30000, n);
    boot(1'b1);
    press(KEY_REDIAL);
    wait_out(0, 1'b1, 1500, n);
    check_eq(n, 1500);
    press(4'h4);
    wait_out(0, 1'b1, 10, n);
    wait_out(0, 1'b0, 3000, n);
    check_digits('{4});
    boot(1'b1);
    press(KEY_REDIAL);
    wait_out(0, 1'b1, 10, n);
    wait_out(0, 1'b0, 3000, n);
    check_digits('{4});
  endtask

  // Key taken in the pre-wait mutes at once, as with a common contact
  task automatic t_early();
    @(negedge sys_clk);
    enable_in = 1'b0;
    repeat (450) @(negedge sys_clk);
    enable_in = 1'b1;
    repeat (TON + 4) @(negedge sys_clk);
    press(4'h6);
    wait_out(0, 1'b1, 10, n);
    check_eq(n, 1);
    wait_out(0, 1'b0, 2000, n);
    check_digits('{6});
  endtask

  // ==========================================================
  // Verdict
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is about 30k cycles
  initial begin
    #(90000 * 50);
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    check_eq({mute_out, digit_strobe_out, line_pulse_out}, 3'b000);
    boot(1'b0);
    boot(1'b1);
    $display("test start-up done");
    t_dial();
    $display("test dial done");
    t_hold();
    $display("test hold done");
    t_redial();
    $display("test redial done");
    t_cut();
    $display("test enable cut done");
    t_ovf();
    $display("test overflow done");
    t_early();
    $display("test early key done");
    wrap_up();
  end
endmodule
